// file: inc/ipc_pkg.sv
// Shared constants and types for the synthesiser control block
package ipc_pkg;
    // ------------------------------------------------------------
    // Clocking and division
    // ------------------------------------------------------------
    localparam int          CLK_HZ    = 25000000;
    localparam int          XTAL_HZ   = 4000000;
    localparam int          REF_DIV   = 400;
    localparam int          REF_HZ    = XTAL_HZ / REF_DIV;
    localparam int          RATIO_W   = 11;
    localparam int          REF_W     = 9;
    localparam logic [10:0] RATIO_MIN = 11'h400;
    localparam logic [10:0] RATIO_MAX = 11'h7ff;

    // ------------------------------------------------------------
    // Bus addressing and byte layout
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_PREFIX = 5'h08;
    localparam logic       ADDR_SEL_HI = 1'b1;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam int         CTRL_FLAG   = 7;
    localparam int         PUMP_BIT    = 6;
    localparam int         MUTE_HI     = 5;
    localparam int         MUTE_LO     = 3;
    localparam int         TEST_HI     = 2;
    localparam int         TEST_LO     = 0;
    localparam int         DIVH_HI     = 5;
    localparam int         DIVH_LO     = 0;
    localparam int         DIVL_HI     = 7;
    localparam int         DIVL_LO     = 3;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] DIVH_RESET   = 8'h20;
    localparam logic [7:0] DIVL_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h80;
    localparam logic [2:0] TEST_NORMAL  = 3'h0;
    localparam logic [2:0] TEST_REF     = 3'h4;
    localparam logic [2:0] TEST_VCO     = 3'h6;
    localparam logic [2:0] TEST_TRI     = 3'h7;
    localparam logic [2:0] TEST_ALL_HIZ = 3'h3;
    localparam logic [2:0] PUMP_LOW     = 3'h1;
    localparam logic [2:0] PUMP_HIGH    = 3'h5;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_ADDR     = 6'h02,
        ST_ADDR_ACK = 6'h04,
        ST_DATA     = 6'h08,
        ST_DATA_ACK = 6'h10,
        ST_IGNORE   = 6'h20
    } ipc_state_type;
endpackage : ipc_pkg

// file: src/ipc_divider.sv
// Programmable edge counter producing a divided square wave
`timescale 1ns/1ps
`default_nettype none
module ipc_divider #(
    parameter int W = 11
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         step,
    input  wire logic [W-1:0] ratio,
    output var  logic         div_level,
    output var  logic         fall_tick
);
    logic [W-1:0] cnt;

    // Wrap check uses >= so a ratio shrunk mid-count cannot overrun
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt       <= '0;
            fall_tick <= 1'b0;
        end else begin
            fall_tick <= 1'b0;
            if (step) begin
                if (cnt >= ratio - W'(1)) begin
                    cnt       <= '0;
                    fall_tick <= 1'b1;
                end else begin
                    cnt <= cnt + W'(1);
                end
            end
        end
    end

    // High in the upper half of the count, so the wrap is the falling edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_level <= 1'b0;
        end else begin
            div_level <= (cnt >= (ratio >> 1));
        end
    end
endmodule : ipc_divider
`default_nettype wire

// file: src/ipc_phase_detector.sv
// Phase/frequency detector driving the charge-pump directions
`timescale 1ns/1ps
`default_nettype none
module ipc_phase_detector (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic vco_fall,
    input  wire logic ref_fall,
    output var  logic source,
    output var  logic sink
);
    logic next_up;
    logic next_dn;

    always_comb begin
        next_up = source | vco_fall;
        next_dn = sink | ref_fall;
        // Both edges seen: phase gap closed, release both directions
        if (next_up && next_dn) begin
            next_up = 1'b0;
            next_dn = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            source <= 1'b0;
            sink   <= 1'b0;
        end else begin
            source <= next_up;
            sink   <= next_dn;
        end
    end
endmodule : ipc_phase_detector
`default_nettype wire

// file: src/ipc_synth_control.sv
// Bus slave, latches, dividers and pump control of the synthesiser
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - VCO signal divided by programmable ratio 1024 to 2047 before comparison.
// - Crystal clock divided by fixed 400 to form the 10 kHz reference.
// - Divided VCO falling first: source pulse for the gap between edges.
// - Reference falling first: sink pulse for the phase difference.
// - Coincident edges: no pump direction, output high-impedance, locked.
// - Control bit selects pump current of one or five units.
// - Data falling while clock high is a start.
// - Bits sampled on rising clock; data changes only while clock low.
// - Data rising while clock high is a stop ending the telegram.
// - Ninth clock of each byte: device pulls data low as acknowledge.
// - First byte is address; respond only to 01000 plus two select bits.
// - Address 0x44 with select input low, 0x46 with it high.
// - Data byte top bit zero means divider bytes, one means control.
// - First divider byte holds two zeros then ratio bits 10 to 5.
// - Second divider byte holds ratio bits 4 to 0 then zeros.
// - Control byte: one, pump bit, three mute bits, three test bits.
// - Test code steers detector pin: normal, reference, VCO, tristate, all off.
// - Each accepted byte goes to divider high, divider low or control latch.
// - Data line only pulled low or released, never driven high.
// - After reset the data line is released.
// - Mute code enables the three audio channels per fixed table.
module ipc_synth_control
    import ipc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe_n,
    input  wire logic       chip_address_select,
    input  wire logic       xtal_in,
    input  wire logic       vco_in,
    output var  logic       pump_source,
    output var  logic       pump_sink,
    output var  logic       pump_current_select,
    output var  logic [2:0] pump_magnitude,
    output var  logic       phase_detector_out,
    output var  logic       phase_detector_oe_n,
    output var  logic       integrator_hiz,
    output var  logic [2:0] channel_on,
    output var  logic [10:0] ratio_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // Bus line sampling and conditions
    // ------------------------------------------------------------
    logic          scl_q;
    logic          sda_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_seen;
    logic          stop_seen;
    ipc_state_type state;
    ipc_state_type next_state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift;
    logic          expect_low;
    logic          addr_match;
    logic          byte_done;
    logic          ack_end;
    logic [7:0]    divider_ratio_high;
    logic [7:0]    divider_ratio_low;
    logic [7:0]    control_word;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    assign scl_rise   = scl_in & ~scl_q;
    assign scl_fall   = ~scl_in & scl_q;
    assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
    assign byte_done  = scl_fall && (bit_cnt == BYTE_BITS);
    assign ack_end    = scl_fall && (state == ST_DATA_ACK);

    // Read requests are not acknowledged: the block is write only
    assign addr_match = (shift[7:1] == {ADDR_PREFIX, ADDR_SEL_HI, chip_address_select})
                        && !shift[0];

    // ------------------------------------------------------------
    // Telegram state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (start_seen) begin
            next_state = ST_ADDR;
        end else if (stop_seen) begin
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        next_state = addr_match ? ST_ADDR_ACK : ST_IGNORE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (byte_done) begin
                        next_state = ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    if (scl_fall) begin
                        next_state = ST_DATA;
                    end
                end
                ST_IGNORE: begin
                    next_state = ST_IGNORE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Bit shifter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else if (start_seen) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && (state == ST_ADDR || state == ST_DATA)) begin
            shift   <= {shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall && (state == ST_ADDR_ACK || state == ST_DATA_ACK)) begin
            bit_cnt <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Open-drain data line
    // ------------------------------------------------------------
    // Pull low for exactly the ninth clock; released out of reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sda_oe_n <= 1'b1;
            sda_out  <= 1'b0;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= !(next_state == ST_ADDR_ACK || next_state == ST_DATA_ACK);
        end
    end

    // ------------------------------------------------------------
    // Latches and ratio commit
    // ------------------------------------------------------------
    // Bytes take effect only at the end of their acknowledge clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divider_ratio_high <= DIVH_RESET;
            divider_ratio_low  <= DIVL_RESET;
            control_word       <= CTRL_RESET;
            expect_low         <= 1'b0;
            ratio_value        <= {DIVH_RESET[DIVH_HI:DIVH_LO], DIVL_RESET[DIVL_HI:DIVL_LO]};
        end else if (start_seen) begin
            expect_low <= 1'b0;
        end else if (ack_end) begin
            if (expect_low) begin
                divider_ratio_low <= shift;
                ratio_value       <= {divider_ratio_high[DIVH_HI:DIVH_LO], shift[DIVL_HI:DIVL_LO]};
                expect_low        <= 1'b0;
            end else if (shift[CTRL_FLAG]) begin
                control_word <= shift;
            end else begin
                divider_ratio_high <= shift;
                expect_low         <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Dividers and phase detector
    // ------------------------------------------------------------
    // Inputs are sampled at 25 MHz: a VCO faster than half that rate aliases
    logic xtal_q;
    logic vco_q;
    logic xtal_step;
    logic vco_step;
    logic ref_level;
    logic ref_fall;
    logic vco_level;
    logic vco_fall;
    logic pfd_source;
    logic pfd_sink;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xtal_q <= 1'b0;
            vco_q  <= 1'b0;
        end else begin
            xtal_q <= xtal_in;
            vco_q  <= vco_in;
        end
    end

    assign xtal_step = xtal_in & ~xtal_q;
    assign vco_step  = vco_in & ~vco_q;

    ipc_divider #(.W(REF_W)) u_ref_div (
        .clk       (clk),
        .nrst      (nrst),
        .step      (xtal_step),
        .ratio     (REF_W'(REF_DIV)),
        .div_level (ref_level),
        .fall_tick (ref_fall)
    );

    ipc_divider #(.W(RATIO_W)) u_vco_div (
        .clk       (clk),
        .nrst      (nrst),
        .step      (vco_step),
        .ratio     (ratio_value),
        .div_level (vco_level),
        .fall_tick (vco_fall)
    );

    ipc_phase_detector u_pfd (
        .clk      (clk),
        .nrst     (nrst),
        .vco_fall (vco_fall),
        .ref_fall (ref_fall),
        .source   (pfd_source),
        .sink     (pfd_sink)
    );

    // ------------------------------------------------------------
    // Pump, test and mute outputs
    // ------------------------------------------------------------
    logic [2:0] test_code;
    assign test_code = control_word[TEST_HI:TEST_LO];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pump_current_select <= CTRL_RESET[PUMP_BIT];
            pump_magnitude      <= PUMP_LOW;
        end else begin
            pump_current_select <= control_word[PUMP_BIT];
            pump_magnitude      <= control_word[PUMP_BIT] ? PUMP_HIGH : PUMP_LOW;
        end
    end

    // Code bit 2 mutes channel 1 and bit 0 channel 3, so the table is a mirrored inversion
    logic [2:0] mute_code;
    assign mute_code = control_word[MUTE_HI:MUTE_LO];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            channel_on <= ~{CTRL_RESET[MUTE_LO], CTRL_RESET[MUTE_LO+1], CTRL_RESET[MUTE_HI]};
        end else begin
            channel_on <= ~{mute_code[0], mute_code[1], mute_code[2]};
        end
    end

    // Unlisted test codes fall back to normal pump operation
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pump_source         <= 1'b0;
            pump_sink           <= 1'b0;
            phase_detector_out  <= 1'b0;
            phase_detector_oe_n <= 1'b1;
            integrator_hiz      <= 1'b0;
        end else begin
            pump_source         <= 1'b0;
            pump_sink           <= 1'b0;
            phase_detector_out  <= 1'b0;
            phase_detector_oe_n <= 1'b1;
            integrator_hiz      <= 1'b0;
            unique case (test_code)
                TEST_REF: begin
                    phase_detector_out  <= ref_level;
                    phase_detector_oe_n <= 1'b0;
                end
                TEST_VCO: begin
                    phase_detector_out  <= vco_level;
                    phase_detector_oe_n <= 1'b0;
                end
                TEST_TRI: begin
                    phase_detector_oe_n <= 1'b1;
                end
                TEST_ALL_HIZ: begin
                    integrator_hiz <= 1'b1;
                end
                default: begin
                    pump_source <= pfd_source;
                    pump_sink   <= pfd_sink;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sda_low_only_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    ack_on_fall_a: assert property ($fell(sda_oe_n) |-> $past(scl_fall))
        else $error("acknowledge not started on a clock fall");
    ack_one_pulse_a: assert property (!sda_oe_n && scl_fall && !start_seen |=> sda_oe_n)
        else $error("acknowledge held past the ninth clock");
    ignore_released_a: assert property (state == ST_IGNORE |-> sda_oe_n)
        else $error("data line pulled after address mismatch");
    pump_exclusive_a: assert property (!(pump_source && pump_sink))
        else $error("both pump directions active");
    test_all_hiz_a: assert property (test_code == TEST_ALL_HIZ && $stable(control_word)
        |=> integrator_hiz && !pump_source && !pump_sink && phase_detector_oe_n)
        else $error("all high-impedance test code not applied");
    ratio_commit_a: assert property ($changed(ratio_value)
        |-> $past(ack_end) && $past(expect_low))
        else $error("ratio changed outside low byte acknowledge");
    ctrl_route_a: assert property ($changed(control_word)
        |-> $past(ack_end) && $past(shift[CTRL_FLAG]) && !$past(expect_low))
        else $error("control latch written by wrong byte");
    mute_map_a: assert property ($stable(control_word)
        |=> channel_on == ~{$past(mute_code[0]), $past(mute_code[1]), $past(mute_code[2])})
        else $error("channel enables do not follow mute code");
    sample_rise_a: assert property (scl_rise && state == ST_DATA && !start_seen
        |=> shift[0] == $past(sda_in))
        else $error("bit not sampled on rising clock");
endmodule : ipc_synth_control
`default_nettype wire

// file: verification/ipc_host_model.sv
// Bus master model that writes telegrams to the synthesiser control block
`timescale 1ns/1ps
`default_nettype none
module ipc_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_pull
);
    // ------------------------------------------------------------
    // Idle bus: both lines released high
    // ------------------------------------------------------------
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold

    // ------------------------------------------------------------
    // Conditions and bits
    // ------------------------------------------------------------
    // Works as a repeated start too: data released before clock rises
    task automatic start_cond();
        @(posedge clk) sda_pull <= 1'b0;
        hold(3);
        @(posedge clk) scl <= 1'b1;
        hold(3);
        @(posedge clk) sda_pull <= 1'b1;
        hold(3);
        @(posedge clk) scl <= 1'b0;
        hold(3);
    endtask : start_cond

    task automatic stop_cond();
        @(posedge clk) sda_pull <= 1'b1;
        hold(3);
        @(posedge clk) scl <= 1'b1;
        hold(3);
        @(posedge clk) sda_pull <= 1'b0;
        hold(3);
    endtask : stop_cond

    // Data moves only while the clock is low, well clear of its edges
    task automatic bit_clk(input logic v, output logic seen);
        @(posedge clk) sda_pull <= ~v;
        hold(3);
        @(posedge clk) scl <= 1'b1;
        hold(3);
        seen = sda_line;
        @(posedge clk) scl <= 1'b0;
        hold(3);
    endtask : bit_clk

    // Ninth clock with the line released, so the slave can pull it low
    task automatic put_byte(input logic [7:0] b, output logic ack_line);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(b[i], s);
        end
        bit_clk(1'b1, ack_line);
    endtask : put_byte
endmodule : ipc_host_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the synthesiser control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ipc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] on;
        logic [2:0] mag;
        logic       hiz;
        logic       oe_n;
    } ipc_row_type;

    logic        clk, nrst, cs, xtal, vco, scl, sda_pull, sda_out, sda_oe_n;
    logic        src, snk, pcs, pd, pd_oe_n, hiz;
    logic [2:0]  mag, on;
    logic [10:0] ratio;
    wire logic   sda_line;
    int          err_total, n_tests, n_src, n_snk, n_pd, vco_half;
    ipc_row_type rows [8];

    // External pull-up: line is low only while someone pulls it
    assign sda_line = ~(sda_pull | ~sda_oe_n);

    ipc_host_model ipc_host_model_inst (
        .clk      (clk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_pull (sda_pull)
    );

    ipc_synth_control ipc_synth_control_inst (
        .clk                 (clk),
        .nrst                (nrst),
        .scl_in              (scl),
        .sda_in              (sda_line),
        .sda_out             (sda_out),
        .sda_oe_n            (sda_oe_n),
        .chip_address_select (cs),
        .xtal_in             (xtal),
        .vco_in              (vco),
        .pump_source         (src),
        .pump_sink           (snk),
        .pump_current_select (pcs),
        .pump_magnitude      (mag),
        .phase_detector_out  (pd),
        .phase_detector_oe_n (pd_oe_n),
        .integrator_hiz      (hiz),
        .channel_on          (on),
        .ratio_value         (ratio)
    );

    // ------------------------------------------------------------
    // Clocks: 25 MHz system, 4 MHz crystal, 10 MHz oscillator
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        xtal = 1'b0;
        // Offset keeps oscillator edges off the sampling clock edge
        #7;
        forever #125 xtal = ~xtal;
    end
    initial begin
        vco      = 1'b0;
        vco_half = 50;
        #7;
        forever #(vco_half) vco = ~vco;
    end

    // ------------------------------------------------------------
    // Checking and telegrams
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // Acknowledge expected on every byte only when ok is set
    task automatic tel(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1, input int n,
                       input logic ok);
        logic s;
        ipc_host_model_inst.start_cond();
        ipc_host_model_inst.put_byte(a, s);
        chk("address ack", {10'h0, ~ok}, {10'h0, s});
        for (int i = 0; i < n; i++) begin
            ipc_host_model_inst.put_byte((i == 0) ? b0 : b1, s);
            chk("data ack", {10'h0, ~ok}, {10'h0, s});
        end
        ipc_host_model_inst.stop_cond();
        repeat (4) @(posedge clk);
    endtask : tel

    task automatic count_pumps(input int n);
        n_src = 0;
        n_snk = 0;
        n_pd  = 0;
        repeat (n) begin
            @(posedge clk);
            n_src += int'(src === 1'b1);
            n_snk += int'(snk === 1'b1);
            n_pd  += int'(pd === 1'b1);
            if (src === 1'b1 && snk === 1'b1) chk("pumps both", 11'h0, 11'h1);
        end
    endtask : count_pumps

    // Watchdog: whole run needs roughly 37000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        n_tests   = 0;
        nrst      = 1'b0;
        cs        = 1'b0;
        rows[0] = '{8'h80, 3'b111, 3'h1, 1'b0, 1'b1};
        rows[1] = '{8'hcc, 3'b011, 3'h5, 1'b0, 1'b0};
        rows[2] = '{8'h96, 3'b101, 3'h1, 1'b0, 1'b0};
        rows[3] = '{8'hdf, 3'b001, 3'h5, 1'b0, 1'b1};
        rows[4] = '{8'ha3, 3'b110, 3'h1, 1'b1, 1'b1};
        rows[5] = '{8'he8, 3'b010, 3'h5, 1'b0, 1'b1};
        rows[6] = '{8'hb0, 3'b100, 3'h1, 1'b0, 1'b1};
        rows[7] = '{8'hf8, 3'b000, 3'h5, 1'b0, 1'b1};
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("released line", 11'h1, {10'h0, sda_oe_n});
        chk("reset ratio", 11'h400, ratio);
        chk("reset magnitude", 11'h1, {8'h0, mag});
        chk("reset channels", 11'h7, {8'h0, on});
        chk("drive value", 11'h0, {10'h0, sda_out});
        foreach (rows[i]) begin
            tel(8'h44, rows[i].ctrl, 8'h00, 1, 1'b1);
            chk("channels", {8'h0, rows[i].on}, {8'h0, on});
            chk("magnitude", {8'h0, rows[i].mag}, {8'h0, mag});
            chk("current bit", {10'h0, rows[i].ctrl[6]}, {10'h0, pcs});
            chk("integrator off", {10'h0, rows[i].hiz}, {10'h0, hiz});
            chk("detector enable", {10'h0, rows[i].oe_n}, {10'h0, pd_oe_n});
            chk("ratio kept", 11'h400, ratio);
        end
        tel(8'h44, 8'h2d, 8'h28, 2, 1'b1);
        chk("ratio", 11'h5a5, ratio);
        tel(8'h44, 8'h0b, 8'h00, 1, 1'b1);
        chk("half ratio", 11'h5a5, ratio);
        cs <= 1'b1;
        tel(8'h44, 8'h80, 8'h00, 1, 1'b0);
        chk("foreign address", 11'h0, {8'h0, on});
        tel(8'h46, 8'h80, 8'h00, 1, 1'b1);
        chk("second address", 11'h7, {8'h0, on});
        tel(8'h47, 8'hf8, 8'h00, 1, 1'b0);
        chk("read refused", 11'h7, {8'h0, on});
        cs <= 1'b0;
        tel(8'h44, 8'h20, 8'h00, 2, 1'b1);
        chk("lowest ratio", 11'h400, ratio);
        // Divided oscillator slightly slower than reference: sink leads
        count_pumps(8000);
        chk("sink active", 11'h1, {10'h0, n_snk > 0});
        // Oscillator sped up so the divided signal leads the reference
        vco_half = 42;
        count_pumps(16000);
        chk("source active", 11'h1, {10'h0, n_src > 0});
        tel(8'h44, 8'h87, 8'h00, 1, 1'b1);
        count_pumps(6000);
        chk("pumps in tristate", 11'h0, 11'(n_src + n_snk));
        tel(8'h44, 8'h84, 8'h00, 1, 1'b1);
        count_pumps(3000);
        chk("reference on pin", 11'h1, {10'h0, n_pd > 0 && n_pd < 3000});
        chk("pumps in test", 11'h0, 11'(n_src + n_snk));
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
